// [src/avgmax_regs.vh]
`ifndef AVGMAX_REGS_VH
`define AVGMAX_REGS_VH

// register byte offsets
`define REG_CTRL        5'h00
`define REG_STATUS      5'h04
`define REG_AVG         5'h08
`define REG_PEAK        5'h0c
`define REG_SAMPLES     5'h10
`define REG_TIMERS      5'h14
`define REG_CMD         5'h18
`define REG_RUN_PEAK    5'h1c

// control field positions
`define CTRL_WIN_MSB    2
`define CTRL_WIN_LSB    0
`define CTRL_DAYS_MSB   16
`define CTRL_DAYS_LSB   8
`define CTRL_HOUR_MSB   28
`define CTRL_HOUR_LSB   24

// control reset: window off, one day, hour 12
`define CTRL_RESET      32'h0c00_0100

// status bit positions
`define ST_RUNNING      0
`define ST_DIV_BUSY     1
`define ST_LOG_EN       2
`define ST_AVG_ON       3
`define ST_PEAK_SEEN    4

// command bit positions
`define CMD_CLEAR       0

// average window encodings
`define WIN_OFF         3'h0
`define WIN_SEL_5       3'h1
`define WIN_SEL_10      3'h2
`define WIN_SEL_15      3'h3
`define WIN_SEL_30      3'h4
`define WIN_SEL_60      3'h5

// window lengths in minutes
`define MIN_5           6'h05
`define MIN_10          6'h0a
`define MIN_15          6'h0f
`define MIN_30          6'h1e
`define MIN_60          6'h3c

`endif

// [src/avg_divider.v]
`timescale 1ns/1ps
module avg_divider #(
	parameter ACC_W = 48,
	parameter CNT_W = 32
) (
	// clock and reset
	input  wire             core_clk,
	input  wire             sys_rst,
	input  wire             clk_en,
	// request
	input  wire             start,
	input  wire [ACC_W-1:0] dividend,
	input  wire [CNT_W-1:0] divisor,
	// result
	output reg              busy_q,
	output reg              done_q,
	output reg  [ACC_W-1:0] quot_q
);
	localparam IW = $clog2(ACC_W + 1);

	reg  [CNT_W:0]   rem_q;
	reg  [CNT_W-1:0] den_q;
	reg  [IW-1:0]    iter_q;
	wire [CNT_W:0]   rem_sh;
	wire             fits;

	assign rem_sh = {rem_q[CNT_W-1:0], quot_q[ACC_W-1]};
	assign fits   = rem_sh >= {1'b0, den_q};

	// restoring division, one quotient bit per cycle
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			quot_q <= {ACC_W{1'b0}};
			rem_q  <= {(CNT_W+1){1'b0}};
			den_q  <= {CNT_W{1'b0}};
			iter_q <= {IW{1'b0}};
		end else if (clk_en) begin
			done_q <= 1'b0;
			if (start && !busy_q) begin
				if (divisor == {CNT_W{1'b0}}) begin
					quot_q <= {ACC_W{1'b0}};
					done_q <= 1'b1;
				end else begin
					quot_q <= dividend;
					den_q  <= divisor;
					rem_q  <= {(CNT_W+1){1'b0}};
					iter_q <= ACC_W[IW-1:0];
					busy_q <= 1'b1;
				end
			end else if (busy_q) begin
				rem_q  <= fits ? rem_sh - {1'b0, den_q} : rem_sh;
				quot_q <= {quot_q[ACC_W-2:0], fits};
				iter_q <= iter_q - {{(IW-1){1'b0}}, 1'b1};
				if (iter_q == {{(IW-1){1'b0}}, 1'b1}) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end
endmodule

// [src/peak_hold.v]
`timescale 1ns/1ps
module peak_hold #(
	parameter VAL_W = 16
) (
	// clock and reset
	input  wire             core_clk,
	input  wire             sys_rst,
	input  wire             clk_en,
	// control
	input  wire             restart,
	input  wire             sample_en,
	input  wire [VAL_W-1:0] sample_value,
	// running peak
	output reg  [VAL_W-1:0] peak_q,
	output reg              seen_q
);
	function [VAL_W-1:0] keep_larger;
		input [VAL_W-1:0] a;
		input [VAL_W-1:0] b;
		begin
			keep_larger = (a > b) ? a : b;
		end
	endfunction

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			peak_q <= {VAL_W{1'b0}};
			seen_q <= 1'b0;
		end else if (clk_en) begin
			if (restart) begin
				seen_q <= sample_en;
				peak_q <= sample_en ? sample_value : {VAL_W{1'b0}};
			end else if (sample_en) begin
				seen_q <= 1'b1;
				peak_q <= seen_q ? keep_larger(peak_q, sample_value) : sample_value;
			end
		end
	end
endmodule

// [src/average_and_maximum_tracker.v]
`timescale 1ns/1ps
`include "avgmax_regs.vh"
module average_and_maximum_tracker #(
	parameter VAL_W = 16,
	parameter CNT_W = 32,
	parameter ACC_W = 48
) (
	// clock, reset, enable
	input  wire             core_clk,
	input  wire             sys_rst,
	input  wire             clk_en,

	// avalon-mm slave
	input  wire [4:0]       avs_address,
	input  wire             avs_read,
	input  wire             avs_write,
	input  wire [31:0]      avs_writedata,
	input  wire [3:0]       avs_byteenable,
	output reg  [31:0]      avs_readdata,
	output reg              avs_waitrequest,

	// real-time clock
	input  wire             rtc_minute_tick,
	input  wire [4:0]       rtc_hour,
	input  wire [5:0]       rtc_minute,

	// measurement and binary inputs
	input  wire             sample_valid,
	input  wire [VAL_W-1:0] sample_value,
	input  wire             value_clear_input,
	input  wire             average_log_enable,

	// supervisory and panel results
	output reg              avg_report_q,
	output reg              avg_log_q,
	output reg  [VAL_W-1:0] avg_value_q,
	output reg              peak_report_q,
	output reg              peak_log_q,
	output reg  [VAL_W-1:0] peak_value_q
);
	localparam ST_WAIT = 2'b01;
	localparam ST_RUN  = 2'b10;

	// window setting to minutes, zero when off
	function [5:0] window_minutes;
		input [2:0] sel;
		begin
			case (sel)
				`WIN_SEL_5: begin
					window_minutes = `MIN_5;
				end
				`WIN_SEL_10: begin
					window_minutes = `MIN_10;
				end
				`WIN_SEL_15: begin
					window_minutes = `MIN_15;
				end
				`WIN_SEL_30: begin
					window_minutes = `MIN_30;
				end
				`WIN_SEL_60: begin
					window_minutes = `MIN_60;
				end
				default: begin
					window_minutes = 6'h00;
				end
			endcase
		end
	endfunction

	// byte-lane merge of a write
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] wdata;
		input [3:0]  be;
		integer i;
		begin
			lane_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					lane_merge[i*8 +: 8] = wdata[i*8 +: 8];
				end
			end
		end
	endfunction

	reg  [1:0]       state_q;
	reg  [1:0]       state_d;
	reg  [31:0]      ctrl_q;
	reg  [ACC_W-1:0] sum_q;
	reg  [CNT_W-1:0] cnt_q;
	reg  [5:0]       min_cnt_q;
	reg  [8:0]       day_cnt_q;
	reg              sw_clear_q;
	reg  [31:0]      read_mux;

	wire [2:0]       average_window_setting;
	wire [8:0]       peak_interval_days;
	wire [4:0]       cycle_start_hour;
	wire [5:0]       win_min;
	wire             avg_on;
	wire             peak_on;
	wire             running;
	wire             hour_hit;
	wire             arm;
	wire             avg_expire;
	wire             peak_expire;
	wire             do_clear;
	wire             avg_take;
	wire             bus_go;
	wire             wr_go;
	wire [ACC_W-1:0] sample_ext;
	wire             div_busy;
	wire             div_done;
	wire [ACC_W-1:0] div_quot;
	wire [VAL_W-1:0] peak_run;
	wire             peak_seen;

	assign average_window_setting = ctrl_q[`CTRL_WIN_MSB:`CTRL_WIN_LSB];
	assign peak_interval_days     = ctrl_q[`CTRL_DAYS_MSB:`CTRL_DAYS_LSB];
	assign cycle_start_hour       = ctrl_q[`CTRL_HOUR_MSB:`CTRL_HOUR_LSB];

	assign win_min = window_minutes(average_window_setting);
	assign avg_on  = win_min != 6'h00;
	assign peak_on = peak_interval_days != 9'h000;
	assign running = state_q == ST_RUN;

	assign hour_hit = rtc_minute_tick && (rtc_hour == cycle_start_hour) &&
		(rtc_minute == 6'h00);
	assign arm      = (state_q == ST_WAIT) && hour_hit;

	assign avg_expire  = running && avg_on && rtc_minute_tick &&
		((min_cnt_q + 6'h01) >= win_min);
	assign peak_expire = running && peak_on && hour_hit &&
		((day_cnt_q + 9'h001) >= peak_interval_days);

	assign do_clear   = value_clear_input | sw_clear_q;
	assign avg_take   = sample_valid && running && avg_on;
	assign sample_ext = {{(ACC_W-VAL_W){1'b0}}, sample_value};
	assign bus_go     = (avs_read | avs_write) & ~avs_waitrequest;
	assign wr_go      = bus_go & avs_write;

	avg_divider #(
		.ACC_W   (ACC_W),
		.CNT_W   (CNT_W)
	) u_div (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.start    (avg_expire),
		.dividend (sum_q),
		.divisor  (cnt_q),
		.busy_q   (div_busy),
		.done_q   (div_done),
		.quot_q   (div_quot)
	);

	peak_hold #(
		.VAL_W (VAL_W)
	) u_peak (
		.core_clk     (core_clk),
		.sys_rst      (sys_rst),
		.clk_en       (clk_en),
		.restart      (do_clear | arm | peak_expire),
		.sample_en    (sample_valid && running && peak_on),
		.sample_value (sample_value),
		.peak_q       (peak_run),
		.seen_q       (peak_seen)
	);

	// run state
	always @* begin
		case (state_q)
			ST_WAIT: begin
				state_d = arm ? ST_RUN : ST_WAIT;
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_WAIT;
			end
		endcase
	end

	// register read mux
	always @* begin
		case (avs_address)
			`REG_CTRL: begin
				read_mux = ctrl_q;
			end
			`REG_STATUS: begin
				read_mux = 32'h0000_0000;
				read_mux[`ST_RUNNING]   = running;
				read_mux[`ST_DIV_BUSY]  = div_busy;
				read_mux[`ST_LOG_EN]    = average_log_enable;
				read_mux[`ST_AVG_ON]    = avg_on;
				read_mux[`ST_PEAK_SEEN] = peak_seen;
			end
			`REG_AVG: begin
				read_mux = {{(32-VAL_W){1'b0}}, avg_value_q};
			end
			`REG_PEAK: begin
				read_mux = {{(32-VAL_W){1'b0}}, peak_value_q};
			end
			`REG_SAMPLES: begin
				read_mux = cnt_q[31:0];
			end
			`REG_TIMERS: begin
				read_mux = {7'h00, day_cnt_q, 10'h000, min_cnt_q};
			end
			`REG_RUN_PEAK: begin
				read_mux = {{(32-VAL_W){1'b0}}, peak_run};
			end
			default: begin
				read_mux = 32'h0000_0000;
			end
		endcase
	end

	// bus slave: one wait cycle, then the access completes
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			ctrl_q          <= `CTRL_RESET;
			sw_clear_q      <= 1'b0;
		end else if (clk_en) begin
			sw_clear_q <= wr_go && (avs_address == `REG_CMD) &&
				avs_byteenable[0] && avs_writedata[`CMD_CLEAR];
			if (bus_go) begin
				avs_waitrequest <= 1'b1;
			end else if (avs_read | avs_write) begin
				avs_waitrequest <= 1'b0;
				avs_readdata    <= avs_read ? read_mux : 32'h0000_0000;
			end
			if (wr_go && (avs_address == `REG_CTRL)) begin
				ctrl_q <= lane_merge(ctrl_q, avs_writedata, avs_byteenable);
			end
		end
	end

	// accumulation and cycle timers
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q   <= ST_WAIT;
			sum_q     <= {ACC_W{1'b0}};
			cnt_q     <= {CNT_W{1'b0}};
			min_cnt_q <= 6'h00;
			day_cnt_q <= 9'h000;
		end else if (clk_en) begin
			state_q <= state_d;
			if (!avg_on || arm) begin
				sum_q     <= {ACC_W{1'b0}};
				cnt_q     <= {CNT_W{1'b0}};
				min_cnt_q <= 6'h00;
			end else begin
				// clear or expiry restarts the sums
				if (do_clear || avg_expire) begin
					sum_q <= avg_take ? sample_ext : {ACC_W{1'b0}};
					cnt_q <= avg_take ? {{(CNT_W-1){1'b0}}, 1'b1} : {CNT_W{1'b0}};
				end else if (avg_take) begin
					sum_q <= sum_q + sample_ext;
					cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
				end
				// window timing not disturbed by clear
				if (avg_expire) begin
					min_cnt_q <= 6'h00;
				end else if (running && rtc_minute_tick) begin
					min_cnt_q <= min_cnt_q + 6'h01;
				end
			end
			if (arm || peak_expire || !peak_on) begin
				day_cnt_q <= 9'h000;
			end else if (running && hour_hit) begin
				day_cnt_q <= day_cnt_q + 9'h001;
			end
		end
	end

	// result outputs
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avg_report_q  <= 1'b0;
			avg_log_q     <= 1'b0;
			avg_value_q   <= {VAL_W{1'b0}};
			peak_report_q <= 1'b0;
			peak_log_q    <= 1'b0;
			peak_value_q  <= {VAL_W{1'b0}};
		end else if (clk_en) begin
			avg_report_q <= div_done;
			avg_log_q    <= div_done & average_log_enable;
			if (div_done) begin
				avg_value_q <= div_quot[VAL_W-1:0];
			end
			peak_report_q <= peak_expire;
			peak_log_q    <= peak_expire;
			if (peak_expire) begin
				peak_value_q <= peak_seen ? peak_run : {VAL_W{1'b0}};
			end
		end
	end
endmodule

// [bench/tracker_monitor.sv]
`timescale 1ns/1ps
module tracker_monitor (
	// clock and reset
	input wire        core_clk,
	input wire        sys_rst,
	// bus and time
	input wire        avs_read,
	input wire        avs_write,
	input wire        avs_waitrequest,
	input wire        rtc_minute_tick,
	input wire [5:0]  rtc_minute,
	input wire        average_log_enable,
	// results
	input wire        avg_report_q,
	input wire        avg_log_q,
	input wire [15:0] avg_value_q,
	input wire        peak_report_q,
	input wire        peak_log_q,
	input wire [15:0] peak_value_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence bus_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence bus_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	bus_wait_a: assert property (bus_req |=> bus_ack)
		else $error("bus answer late or too long");
	avg_pulse_a: assert property (avg_report_q |=> !avg_report_q)
		else $error("average report longer than one cycle");
	avg_log_a: assert property (avg_report_q |-> avg_log_q == $past(average_log_enable))
		else $error("average log does not follow enable");
	log_alone_a: assert property (avg_log_q |-> avg_report_q)
		else $error("average logged without report");
	avg_hold_a: assert property (!avg_report_q |-> $stable(avg_value_q))
		else $error("average changed without report");
	peak_pair_a: assert property (peak_report_q == peak_log_q)
		else $error("peak report and log apart");
	peak_hold_a: assert property (!peak_report_q |-> $stable(peak_value_q))
		else $error("peak changed without report");
	peak_tick_a: assert property (peak_report_q |->
		$past(rtc_minute_tick) && $past(rtc_minute) == 6'h00)
		else $error("peak report off the hour tick");
endmodule

bind average_and_maximum_tracker tracker_monitor i_mon (.core_clk(core_clk), .sys_rst(sys_rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.rtc_minute_tick(rtc_minute_tick), .rtc_minute(rtc_minute),
	.average_log_enable(average_log_enable), .avg_report_q(avg_report_q),
	.avg_log_q(avg_log_q), .avg_value_q(avg_value_q), .peak_report_q(peak_report_q),
	.peak_log_q(peak_log_q), .peak_value_q(peak_value_q));

// [bench/sup_panel_model.sv]
`timescale 1ns/1ps
module sup_panel_model (
	// clock
	input wire        core_clk,
	// reports
	input wire        avg_report_q,
	input wire        avg_log_q,
	input wire [15:0] avg_value_q,
	input wire        peak_report_q,
	input wire        peak_log_q,
	input wire [15:0] peak_value_q
);
	int          avg_n = 0;
	int          log_n = 0;
	int          peak_n = 0;
	int          plog_n = 0;
	logic [15:0] avg_v = 16'h0000;
	logic [15:0] peak_v = 16'h0000;
	// tallies of supervisory and panel traffic
	always @(posedge core_clk) begin
		if (avg_report_q) begin
			avg_n <= avg_n + 1;
			avg_v <= avg_value_q;
		end
		if (avg_log_q)
			log_n <= log_n + 1;
		if (peak_report_q) begin
			peak_n <= peak_n + 1;
			peak_v <= peak_value_q;
		end
		if (peak_log_q)
			plog_n <= plog_n + 1;
	end
endmodule

// [bench/tb_average_and_maximum_tracker.sv]
`timescale 1ns/1ps
module tb_average_and_maximum_tracker;
	logic        core_clk = 0;
	logic        sys_rst = 1;
	logic        clk_en = 1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 0;
	logic        avs_write = 0;
	logic [31:0] avs_writedata = 32'h0;
	wire [31:0]  avs_readdata;
	wire         avs_waitrequest;
	logic        tick = 0;
	logic [4:0]  hour = 5'h00;
	logic [5:0]  minute = 6'h00;
	logic        sample_valid = 0;
	logic [15:0] sample_value = 16'h0;
	logic        value_clear_input = 0;
	logic        average_log_enable = 0;
	wire         ar, al, pr, pl;
	wire [15:0]  av, pv;
	logic [31:0] rd;
	int          err_total = 0;
	int          samples_checked = 0;

	always #10 core_clk = ~core_clk;

	average_and_maximum_tracker i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rtc_minute_tick(tick), .rtc_hour(hour),
		.rtc_minute(minute), .sample_valid(sample_valid), .sample_value(sample_value),
		.value_clear_input(value_clear_input), .average_log_enable(average_log_enable),
		.avg_report_q(ar), .avg_log_q(al), .avg_value_q(av),
		.peak_report_q(pr), .peak_log_q(pl), .peak_value_q(pv));
	sup_panel_model i_sup (.core_clk(core_clk), .avg_report_q(ar), .avg_log_q(al),
		.avg_value_q(av), .peak_report_q(pr), .peak_log_q(pl), .peak_value_q(pv));

	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		if (n >= 50) chk("bus answer", 0, 1);
		@(posedge core_clk);
	endtask
	task rtc(input logic [4:0] h, input logic [5:0] m);
		hour <= h;
		minute <= m;
		tick <= 1;
		@(posedge core_clk);
		tick <= 0;
		repeat (3) @(posedge core_clk);
	endtask
	task smp(input logic [15:0] v);
		sample_value <= v;
		sample_valid <= 1;
		@(posedge core_clk);
		sample_valid <= 0;
		@(posedge core_clk);
	endtask
	task t_defaults;
		bus(0, 5'h00, 32'h0);
		chk("ctrl reset", 32'h0c00_0100, rd);
		for (int w = 0; w < 6; w++) begin
			bus(1, 5'h00, 32'h0c00_0100 | w);
			bus(0, 5'h00, 32'h0);
			chk("ctrl window", 32'h0c00_0100 | w, rd);
		end
		bus(0, 5'h02, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("defaults done");
	endtask
	task t_average;
		bus(1, 5'h00, 32'h0c00_0101);
		average_log_enable <= 1;
		rtc(5'h0b, 6'h00);
		bus(0, 5'h04, 32'h0);
		chk("wrong hour idle", 32'h0, {31'h0, rd[0]});
		rtc(5'h0c, 6'h00);
		bus(0, 5'h04, 32'h0);
		chk("start hour run", 32'h1, {31'h0, rd[0]});
		smp(16'h000a);
		smp(16'h0014);
		smp(16'h001f);
		for (int m = 1; m <= 5; m++) rtc(5'h0c, m[5:0]);
		repeat (80) @(posedge core_clk);
		chk("avg count", 32'h1, i_sup.avg_n);
		chk("avg value", 32'h14, i_sup.avg_v);
		chk("avg logs", 32'h1, i_sup.log_n);
		average_log_enable <= 0;
		smp(16'h0007);
		smp(16'h0008);
		for (int m = 6; m <= 10; m++) rtc(5'h0c, m[5:0]);
		repeat (80) @(posedge core_clk);
		chk("avg count", 32'h2, i_sup.avg_n);
		chk("avg value", 32'h7, i_sup.avg_v);
		chk("avg logs", 32'h1, i_sup.log_n);
		chk("no early peak", 32'h0, i_sup.peak_n);
		clk_en <= 0;
		rtc(5'h0c, 6'h0b);
		clk_en <= 1;
		bus(0, 5'h14, 32'h0);
		chk("frozen timers", 32'h0, rd);
		$display("average done");
	endtask
	task t_peak;
		value_clear_input <= 1;
		@(posedge core_clk);
		value_clear_input <= 0;
		smp(16'h0005);
		smp(16'h0009);
		rtc(5'h0c, 6'h00);
		repeat (5) @(posedge core_clk);
		chk("peak count", 32'h1, i_sup.peak_n);
		chk("peak value", 32'h9, i_sup.peak_v);
		chk("peak logs", 32'h1, i_sup.plog_n);
		bus(1, 5'h00, 32'h0c00_0001);
		smp(16'h0028);
		rtc(5'h0c, 6'h00);
		repeat (5) @(posedge core_clk);
		chk("days off", 32'h1, i_sup.peak_n);
		$display("peak done");
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#500us;
		err_total++;
		complete_run;
	end
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 0;
		@(posedge core_clk);
		t_defaults;
		t_average;
		t_peak;
		complete_run;
	end
endmodule
